// file: verilog/rcs_pkg.sv
// Operation
// R1: Command code write starts the selected operation
// R2: Stream operations consume FIFO bytes at once
// R3: Argument operations wait for all argument bytes
// R4: Command start never clears the FIFO
// R5: New command aborts running one, except init
// R6: Init code 3Fh runs only after reset
// R7: Idle code 00h cancels, exchanges no data
// R8: Code 1Ah transmits FIFO stream, returns nothing
// R9: Code 16h waits receive delay, then receives
// R10: Host uses standalone receive only for testing
// R11: Code 1Eh transmits, waits delay, then receives
// R12: Code 01h writes NVM: addr low, high, data
// R13: Code 03h reads count NVM bytes to FIFO
// R14: NVM read never returns key locations
// R15: Code 0Bh copies NVM key into key buffer
// R16: Code 19h loads twelve FIFO bytes, LSB first
// R17: Code 0Ch auth phase one, six bytes
// R18: Code 14h auth phase two, no data
// R19: Code 07h loads configuration from NVM address
// R20: Code 12h computes CRC over FIFO stream
// R21: Completion returns idle and sets idle flag
// R22: Init ends in idle; host waits for it
// R23: Idle abort leaves FIFO contents intact
// R24: Unknown code behaves like idle code
`default_nettype none
package rcs_pkg;
    // Command codes
    localparam logic [7:0] CMD_IDLE     = 8'h00;
    localparam logic [7:0] CMD_INIT     = 8'h3f;
    localparam logic [7:0] CMD_TX       = 8'h1a;
    localparam logic [7:0] CMD_RX       = 8'h16;
    localparam logic [7:0] CMD_TRX      = 8'h1e;
    localparam logic [7:0] CMD_NVM_WR   = 8'h01;
    localparam logic [7:0] CMD_NVM_RD   = 8'h03;
    localparam logic [7:0] CMD_KEY_NVM  = 8'h0b;
    localparam logic [7:0] CMD_KEY_FIFO = 8'h19;
    localparam logic [7:0] CMD_AUTH1    = 8'h0c;
    localparam logic [7:0] CMD_AUTH2    = 8'h14;
    localparam logic [7:0] CMD_CFG      = 8'h07;
    localparam logic [7:0] CMD_CRC      = 8'h12;
    // Argument byte counts
    localparam logic [3:0] ARGS_ADDR    = 4'h2;
    localparam logic [3:0] ARGS_NVM_RD  = 4'h3;
    localparam logic [3:0] ARGS_KEY     = 4'hc;
    localparam logic [3:0] ARGS_AUTH1   = 4'h6;
    // Key buffer and configuration block sizes in bytes
    localparam logic [7:0] KEY_BYTES    = 8'h0c;
    localparam logic [7:0] CFG_BYTES    = 8'h10;
    // NVM layout: start-up block at zero, keys from KEY_BASE up
    localparam logic [15:0] CFG_BOOT_ADDR = 16'h0000;
    localparam logic [15:0] KEY_BASE      = 16'h0080;
    // CRC coprocessor preset and reflected polynomial
    localparam logic [15:0] CRC_PRESET  = 16'h6363;
    localparam logic [15:0] CRC_POLY    = 16'h8408;
    // Controller register byte offsets (AHB-Lite)
    localparam logic [3:0] REG_CMD      = 4'h0;
    localparam logic [3:0] REG_FIFO     = 4'h4;
    localparam logic [3:0] REG_STATUS   = 4'h8;
    localparam logic [3:0] REG_CRC      = 4'hc;
    // Sequencer states
    typedef enum logic [3:0] {
        RCS_IDLE, RCS_ARGS, RCS_RUN, RCS_TX, RCS_RECEIVE_DELAY_SETTING, RCS_RX, RCS_NVM_WR,
        RCS_NVM_RD, RCS_KEY_NVM, RCS_AUTH, RCS_CFG, RCS_CRC
    } rcs_state_t;

    // One byte through the CRC, LSB first
    function automatic logic [15:0] rcs_crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// file: verilog/rcs_if.sv
`default_nettype none
// Host to reader link, all on one clock
interface rcs_if;
    logic       cmd_wr;       // Command code strobe
    logic [7:0] cmd_code;     // Command code
    logic       fifo_wr;      // Push strobe
    logic [7:0] fifo_wdata;   // Push byte
    logic       fifo_rd;      // Pop strobe
    logic [7:0] fifo_rdata;   // FIFO head byte
    logic [6:0] fifo_level;   // Bytes held
    logic [7:0] cmd_active;   // Running command code
    logic       init_busy;    // Start-up still running
    logic       idle_flag;    // Sticky completion flag
    logic       idle_clr;     // Clear strobe for idle_flag
    logic       key_refused;  // Last read touched key area
    logic [7:0] crc_low;      // CRC result low byte
    logic [7:0] crc_high;     // CRC result high byte
    modport dev  (input cmd_wr, cmd_code, fifo_wr, fifo_wdata, fifo_rd, idle_clr,
                  output fifo_rdata, fifo_level, cmd_active, init_busy, idle_flag,
                  key_refused, crc_low, crc_high);
    modport host (output cmd_wr, cmd_code, fifo_wr, fifo_wdata, fifo_rd, idle_clr,
                  input fifo_rdata, fifo_level, cmd_active, init_busy, idle_flag,
                  key_refused, crc_low, crc_high);
endinterface
`default_nettype wire

// file: verilog/rcs_device.sv
`default_nettype none
// Reader command sequencer, device end
module rcs_device
    import rcs_pkg::*;
#(
    parameter int FIFO_DEPTH = 64,    // FIFO bytes
    parameter int NVM_BYTES  = 512,   // NVM size in bytes
    parameter int RX_DIV     = 8      // Clocks per receive delay unit
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    rcs_if.dev               lnk,
    input  wire logic [7:0]  receive_delay_setting,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             rx_enable,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_end,
    output logic             auth1_go,
    output logic [47:0]      auth1_args,
    output logic             auth2_go,
    input  wire logic        auth_done,
    output logic [95:0]      key_buffer,
    output logic             cfg_we,
    output logic [7:0]       cfg_addr,
    output logic [7:0]       cfg_data,
    input  wire logic        nvm_prog_we,
    input  wire logic [15:0] nvm_prog_addr,
    input  wire logic [7:0]  nvm_prog_data
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int AW = $clog2(NVM_BYTES);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        rcs_state_t  st;          // Sequencer state
        logic        booting;     // Start-up load running
        logic [7:0]  cmd;         // Current command
        logic [3:0]  need;        // Argument bytes required
        logic [3:0]  got;         // Argument bytes taken
        logic [95:0] arg;         // Argument bytes, first in low byte
        logic [15:0] addr;        // NVM pointer
        logic [7:0]  cnt;         // Byte counter
        logic        sent;        // Transmit saw a first byte
        logic [7:0]  div;         // Delay unit divider
        logic [7:0]  dly;         // Delay units elapsed
        logic [15:0] crc;         // CRC register
        logic [95:0] key;         // Key buffer
        logic        idle_flag;   // Completion flag
        logic        refused;     // Key read refused
        logic        cfg_we;      // Config write pulse
        logic [7:0]  cfg_addr;    // Config register index
        logic [7:0]  cfg_data;    // Config value
        logic        auth1_go;    // Auth phase one pulse
        logic        auth2_go;    // Auth phase two pulse
        logic [PW:0] wp;          // FIFO write pointer
        logic [PW:0] rp;          // FIFO read pointer
    } rcs_dev_t;

    rcs_dev_t   q, d;
    logic [7:0] fifo_mem [FIFO_DEPTH];   // FIFO storage
    logic [7:0] nvm_mem  [NVM_BYTES];    // Non-volatile store model
    logic [7:0] head;                    // FIFO head byte
    logic [7:0] nvm_q;                   // NVM byte at pointer
    logic [PW:0] level;                  // FIFO occupancy
    logic       empty, full;             // FIFO status
    logic       h_push, h_pop;           // Host FIFO access
    logic       e_push, e_pop;           // Engine FIFO access
    logic [7:0] e_data;                  // Engine push byte
    logic       can_pop, can_push;       // Engine FIFO slots free of host
    logic       nvm_we;                  // Engine NVM write
    logic       done;                    // Operation completes

    assign level    = q.wp - q.rp;
    assign empty    = (level == '0);
    assign full     = (level == (PW+1)'(FIFO_DEPTH));
    assign head     = fifo_mem[q.rp[PW-1:0]];
    assign nvm_q    = nvm_mem[q.addr[AW-1:0]];
    assign h_push   = lnk.fifo_wr && !full;
    assign h_pop    = lnk.fifo_rd && !empty;
    // Host accesses win; the engine retries next cycle, except in receive, where the byte is dropped
    assign can_pop  = !empty && !lnk.fifo_rd;
    assign can_push = !full && !lnk.fifo_wr;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d          = q;
        d.cfg_we   = 1'b0;
        d.auth1_go = 1'b0;
        d.auth2_go = 1'b0;
        d.idle_flag = q.idle_flag & ~lnk.idle_clr;
        e_push     = 1'b0;
        e_pop      = 1'b0;
        e_data     = 8'h00;
        nvm_we     = 1'b0;
        done       = 1'b0;
        case (q.st)
            RCS_IDLE: begin
            end
            // Collect arguments before anything else happens
            RCS_ARGS: begin
                if (can_pop) begin // R3
                    e_pop = 1'b1;
                    d.arg[q.got*8 +: 8] = head;
                    d.got = q.got + 4'h1;
                    if (q.got == q.need - 4'h1) begin
                        d.st = RCS_RUN;
                    end
                end
            end
            // Dispatch once arguments are complete
            RCS_RUN: begin
                d.addr = q.arg[15:0]; // R12 R13 R15 R19
                d.cnt  = '0;
                case (q.cmd)
                    CMD_NVM_WR: d.st = RCS_NVM_WR;
                    CMD_NVM_RD: begin
                        d.cnt = q.arg[23:16]; // R13
                        d.st  = RCS_NVM_RD;
                        if (q.arg[23:16] == 8'h00) begin
                            done = 1'b1;
                        end
                    end
                    CMD_KEY_NVM: d.st = RCS_KEY_NVM; // R15
                    CMD_KEY_FIFO: begin
                        d.key = q.arg; // R16
                        done  = 1'b1;
                    end
                    CMD_AUTH1: begin
                        d.auth1_go = 1'b1; // R17
                        d.st       = RCS_AUTH;
                    end
                    CMD_CFG: d.st = RCS_CFG; // R19
                    default: done = 1'b1;
                endcase
            end
            // Stream FIFO bytes to the transmitter
            RCS_TX: begin
                if (tx_ready && can_pop) begin // R2 R8
                    e_pop  = 1'b1;
                    d.sent = 1'b1;
                end else if (tx_ready && empty && q.sent) begin
                    if (q.cmd == CMD_TRX) begin // R11
                        d.st  = RCS_RECEIVE_DELAY_SETTING;
                        d.div = '0;
                        d.dly = '0;
                    end else begin
                        done = 1'b1;
                    end
                end
            end
            // Hold the receiver off for the programmed delay
            RCS_RECEIVE_DELAY_SETTING: begin
                if (q.dly >= receive_delay_setting) begin // R9 R11
                    d.st = RCS_RX;
                end else if (q.div == 8'(RX_DIV - 1)) begin
                    d.div = '0;
                    d.dly = q.dly + 8'h01;
                end else begin
                    d.div = q.div + 8'h01;
                end
            end
            // Receiver bytes go into the FIFO; a byte into a full FIFO is lost
            RCS_RX: begin
                if (rx_valid && !full) begin // R9
                    e_push = 1'b1;
                    e_data = rx_data;
                end
                if (rx_end) begin
                    done = 1'b1;
                end
            end
            // FIFO stream into NVM from the start address
            RCS_NVM_WR: begin
                if (can_pop) begin // R12
                    e_pop  = 1'b1;
                    nvm_we = 1'b1;
                    d.addr = q.addr + 16'h0001;
                end else if (empty) begin
                    done = 1'b1;
                end
            end
            // NVM bytes into the FIFO, refusing the key area
            RCS_NVM_RD: begin
                if (q.addr >= KEY_BASE) begin // R14
                    d.refused = 1'b1;
                    done      = 1'b1;
                end else if (can_push) begin // R13
                    e_push = 1'b1;
                    e_data = nvm_q;
                    d.addr = q.addr + 16'h0001;
                    d.cnt  = q.cnt - 8'h01;
                    if (q.cnt == 8'h01) begin
                        done = 1'b1;
                    end
                end
            end
            // Twelve key bytes from NVM, LSB first
            RCS_KEY_NVM: begin
                d.key[q.cnt*8 +: 8] = nvm_q; // R15
                d.addr = q.addr + 16'h0001;
                d.cnt  = q.cnt + 8'h01;
                if (q.cnt == KEY_BYTES - 8'h01) begin
                    done = 1'b1;
                end
            end
            // Cipher engine runs outside this block
            RCS_AUTH: begin
                if (auth_done) begin // R17 R18
                    done = 1'b1;
                end
            end
            // Copy a configuration block into the registers
            RCS_CFG: begin
                d.cfg_we   = 1'b1; // R19 R6
                d.cfg_addr = q.cnt;
                d.cfg_data = nvm_q;
                d.addr     = q.addr + 16'h0001;
                d.cnt      = q.cnt + 8'h01;
                if (q.cnt == CFG_BYTES - 8'h01) begin
                    done      = 1'b1; // R22
                    d.booting = 1'b0;
                end
            end
            // CRC over the FIFO stream, nothing returned through it
            RCS_CRC: begin
                if (can_pop) begin // R2 R20
                    e_pop = 1'b1;
                    d.crc = rcs_crc_byte(q.crc, head);
                end else if (empty) begin
                    done = 1'b1;
                end
            end
            default: d.st = RCS_IDLE;
        endcase
        // Own completion returns to idle and raises the flag
        if (done) begin
            d.st        = RCS_IDLE; // R21
            d.cmd       = CMD_IDLE;
            d.idle_flag = 1'b1;
        end
        // A host command aborts anything but the start-up load; no flag
        if (lnk.cmd_wr && !q.booting) begin // R1 R5
            d.cmd       = lnk.cmd_code;
            d.idle_flag = done | (q.idle_flag & ~lnk.idle_clr);
            d.got       = '0;
            d.sent      = 1'b0;
            d.refused   = 1'b0;
            d.div       = '0;
            d.dly       = '0;
            d.st        = RCS_IDLE;
            // FIFO pointers are untouched here so preloaded bytes survive
            case (lnk.cmd_code) // R4 R23
                CMD_TX, CMD_TRX: d.st = RCS_TX; // R8 R11
                CMD_RX: d.st = RCS_RECEIVE_DELAY_SETTING; // R9
                CMD_CRC: begin
                    d.crc = CRC_PRESET; // R20
                    d.st  = RCS_CRC;
                end
                CMD_AUTH2: begin
                    d.auth2_go = 1'b1; // R18
                    d.st       = RCS_AUTH;
                end
                CMD_NVM_WR, CMD_KEY_NVM, CMD_CFG: begin
                    d.need = ARGS_ADDR;
                    d.st   = RCS_ARGS;
                end
                CMD_NVM_RD: begin
                    d.need = ARGS_NVM_RD;
                    d.st   = RCS_ARGS;
                end
                CMD_KEY_FIFO: begin
                    d.need = ARGS_KEY;
                    d.st   = RCS_ARGS;
                end
                CMD_AUTH1: begin
                    d.need = ARGS_AUTH1;
                    d.st   = RCS_ARGS;
                end
                // Idle, start-up code and unknown codes just stop
                default: d.cmd = CMD_IDLE; // R6 R7 R24
            endcase
        end
        d.wp = q.wp + (PW+1)'(h_push | e_push);
        d.rp = q.rp + (PW+1)'(h_pop | e_pop);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset lands in the start-up load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q         <= '0;
            q.st      <= RCS_CFG; // R6
            q.booting <= 1'b1;
            q.cmd     <= CMD_INIT;
            q.addr    <= CFG_BOOT_ADDR;
            q.crc     <= CRC_PRESET;
        end else begin
            q <= d;
        end
    end

    // FIFO and NVM storage; host push wins the single write port
    always_ff @(posedge clk) begin
        if (h_push) begin
            fifo_mem[q.wp[PW-1:0]] <= lnk.fifo_wdata;
        end else if (e_push) begin
            fifo_mem[q.wp[PW-1:0]] <= e_data;
        end
        if (nvm_prog_we) begin
            nvm_mem[nvm_prog_addr[AW-1:0]] <= nvm_prog_data;
        end else if (nvm_we) begin
            nvm_mem[q.addr[AW-1:0]] <= head;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign tx_valid        = (q.st == RCS_TX) && can_pop;
    assign tx_data         = head;
    assign rx_enable       = (q.st == RCS_RX);
    assign auth1_go        = q.auth1_go;
    assign auth1_args      = q.arg[47:0];
    assign auth2_go        = q.auth2_go;
    assign key_buffer      = q.key;
    assign cfg_we          = q.cfg_we;
    assign cfg_addr        = q.cfg_addr;
    assign cfg_data        = q.cfg_data;
    assign lnk.fifo_rdata  = head;
    assign lnk.fifo_level  = 7'(level);
    assign lnk.cmd_active  = q.cmd;
    assign lnk.init_busy   = q.booting;
    assign lnk.idle_flag   = q.idle_flag;
    assign lnk.key_refused = q.refused;
    assign lnk.crc_low     = q.crc[7:0];
    assign lnk.crc_high    = q.crc[15:8];
endmodule
`default_nettype wire

// file: verilog/rcs_host.sv
`default_nettype none
// Host controller end: AHB-Lite registers driving the reader link
module rcs_host
    import rcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    rcs_if.host              lnk,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic        wr_pend;    // Write data phase pending
        logic [3:0]  wr_off;     // Write offset
        logic [31:0] rdata;      // Read data for the data phase
        logic        cmd_wr;     // Command strobe
        logic [7:0]  cmd_code;   // Command code
        logic        fifo_wr;    // Push strobe
        logic [7:0]  fifo_wdata; // Push byte
        logic        fifo_rd;    // Pop strobe
        logic        idle_clr;   // Flag clear strobe
    } rcs_host_t;

    rcs_host_t q, d;
    logic      take;             // Address phase accepted

    // Only NONSEQ or SEQ transfers count; size is always a word here
    assign take = hsel && htrans[1] && hready;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d          = q;
        d.cmd_wr   = 1'b0;
        d.fifo_wr  = 1'b0;
        d.fifo_rd  = 1'b0;
        d.idle_clr = 1'b0;
        // Writes land in the data phase, once hwdata stands
        if (q.wr_pend) begin
            d.wr_pend = 1'b0;
            // Writes during start-up are dropped
            if (!lnk.init_busy) begin // R22
                case (q.wr_off)
                    REG_CMD: begin
                        d.cmd_wr   = 1'b1; // R1
                        d.cmd_code = hwdata[7:0];
                    end
                    REG_FIFO: begin
                        d.fifo_wr    = 1'b1; // R4
                        d.fifo_wdata = hwdata[7:0];
                    end
                    REG_STATUS: d.idle_clr = hwdata[0];
                    default: d.cmd_wr = 1'b0;
                endcase
            end
        end
        // Reads are sampled in the address phase
        if (take) begin
            d.wr_pend = hwrite;
            d.wr_off  = {haddr[3:2], 2'b00};
            if (!hwrite) begin
                case ({haddr[3:2], 2'b00})
                    REG_CMD:    d.rdata = {23'h000000, lnk.init_busy, lnk.cmd_active};
                    REG_FIFO: begin
                        d.rdata   = {24'h000000, lnk.fifo_rdata};
                        d.fifo_rd = (lnk.fifo_level != 7'h00);
                    end
                    REG_STATUS: d.rdata = {16'h0000, 1'b0, lnk.fifo_level,
                                           6'h00, lnk.key_refused, lnk.idle_flag};
                    REG_CRC:    d.rdata = {16'h0000, lnk.crc_high, lnk.crc_low}; // R20
                    default:    d.rdata = 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Zero wait states, always OKAY
    assign hrdata         = q.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign lnk.cmd_wr     = q.cmd_wr;
    assign lnk.cmd_code   = q.cmd_code;
    assign lnk.fifo_wr    = q.fifo_wr;
    assign lnk.fifo_wdata = q.fifo_wdata;
    assign lnk.fifo_rd    = q.fifo_rd;
    assign lnk.idle_clr   = q.idle_clr;
endmodule
`default_nettype wire

// file: tb/rcs_props.sv
`default_nettype none
// Link rule watcher, beside the interface
module rcs_props
    import rcs_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic       fifo_wr,
    input wire logic       fifo_rd,
    input wire logic [6:0] fifo_level,
    input wire logic [7:0] cmd_active,
    input wire logic       init_busy,
    input wire logic       idle_flag
);
    logic go; // Code that starts real work
    assign go = cmd_code inside {CMD_TX, CMD_RX, CMD_TRX, CMD_NVM_WR, CMD_NVM_RD,
        CMD_KEY_NVM, CMD_KEY_FIFO, CMD_AUTH1, CMD_AUTH2, CMD_CFG, CMD_CRC};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_init_held: assert property (init_busy |-> cmd_active == CMD_INIT)
        else $error("start-up not held");
    a_cmd_start: assert property (cmd_wr && !init_busy && go |=> cmd_active == $past(cmd_code))
        else $error("command not started");
    a_idle_code: assert property (cmd_wr && !init_busy && !go |=> cmd_active == 8'h00)
        else $error("idle code ignored");
    a_abort_quiet: assert property (cmd_wr && !init_busy && !idle_flag |=> !idle_flag)
        else $error("abort set flag");
    a_fifo_kept: assert property (cmd_wr && cmd_active == 8'h00 && !fifo_wr && !fifo_rd
        |=> $stable(fifo_level)) else $error("fifo changed");
    a_done_flag: assert property (cmd_active != 8'h00 && !cmd_wr ##1 cmd_active == 8'h00
        |-> idle_flag) else $error("no idle flag");
    a_init_end: assert property ($fell(init_busy) |-> idle_flag && cmd_active == 8'h00)
        else $error("bad start-up end");
    a_crc_pops: assert property (cmd_active == CMD_CRC && fifo_level != 7'h00 && !fifo_wr
        && !fifo_rd |=> fifo_level == $past(fifo_level) - 7'h01) else $error("no pop");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top
    import rcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = '0, reset_n = '0, hsel = '0, hwrite = '0, tx_rdy = '0, ev = '0;
    logic [1:0]  htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
    logic [7:0]  pd = 8'h9e;      // Received byte
    logic        hreadyout, hresp;
    int          error_cnt = 0, samples_checked = 0;
    rcs_if lnk();
    // Free-running bus clock
    always #12.5 clk = ~clk;
    rcs_device #(.RX_DIV(1)) rcs_device_i (.clk(clk), .reset_n(reset_n), .lnk(lnk),
        .receive_delay_setting(8'h01), .tx_ready(tx_rdy), .tx_valid(), .tx_data(),
        .rx_enable(), .rx_valid(ev), .rx_data(pd), .rx_end(ev), .auth1_go(),
        .auth1_args(), .auth2_go(), .auth_done(ev), .key_buffer(), .cfg_we(),
        .cfg_addr(), .cfg_data(), .nvm_prog_we(1'h0), .nvm_prog_addr(16'h0000),
        .nvm_prog_data(8'h00));
    rcs_host rcs_host_i (.clk(clk), .reset_n(reset_n), .lnk(lnk), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    rcs_props rcs_props_i (.clk(clk), .reset_n(reset_n), .cmd_wr(lnk.cmd_wr),
        .cmd_code(lnk.cmd_code), .fifo_wr(lnk.fifo_wr), .fifo_rd(lnk.fifo_rd),
        .fifo_level(lnk.fifo_level), .cmd_active(lnk.cmd_active),
        .init_busy(lnk.init_busy), .idle_flag(lnk.idle_flag));
    // One single word transfer; waits on the bus ready, watchdog bounds it
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {28'h0, a};
        hwrite <= w;
        do @(posedge clk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!hreadyout);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED reg %h exp %h seen %h", haddr, e, s);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'h0, a, '0);
        chk(r, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        bus(1'h1, REG_CMD, {24'h0, c});
        repeat (8) @(posedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'h1;
        repeat (40) @(posedge clk);
        rd(REG_STATUS, 32'h1);
        bus(1'h1, REG_STATUS, 32'h1);
        // Transmit holds preloaded bytes until the transmitter asks
        bus(1'h1, REG_FIFO, 32'h5a);
        bus(1'h1, REG_FIFO, 32'ha5);
        cmd(CMD_TX);
        rd(REG_STATUS, 32'h200);
        tx_rdy <= 1'h1;
        repeat (6) @(posedge clk);
        tx_rdy <= 1'h0;
        rd(REG_STATUS, 32'h1);
        bus(1'h1, REG_STATUS, 32'h1);
        // Short argument list waits, then abort
        bus(1'h1, REG_FIFO, 32'h60);
        cmd(CMD_AUTH1);
        chk({24'h0, lnk.cmd_active}, {24'h0, CMD_AUTH1});
        cmd(CMD_IDLE);
        rd(REG_STATUS, 32'h0);
        // Inactive codes keep the FIFO byte
        bus(1'h1, REG_FIFO, 32'h3c);
        for (int i = 0; i < 3; i++) begin
            cmd(i == 0 ? CMD_IDLE : (i == 1 ? CMD_INIT : 8'h55));
            rd(REG_STATUS, 32'h100);
        end
        rd(REG_FIFO, 32'h3c);
        bus(1'h1, REG_FIFO, 32'h11);
        cmd(CMD_CRC);
        rd(REG_STATUS, 32'h1);
        rd(REG_CRC, 32'h50f6);
        bus(1'h1, REG_STATUS, 32'h1);
        // Read aimed at key storage is refused
        for (int i = 0; i < 3; i++)
            bus(1'h1, REG_FIFO, i == 0 ? 32'h80 : {30'h0, i[1:0]});
        cmd(CMD_NVM_RD);
        rd(REG_STATUS, 32'h3);
        bus(1'h1, REG_STATUS, 32'h1);
        for (int i = 0; i < 2; i++) begin
            cmd(i == 0 ? CMD_AUTH2 : CMD_RX);
            ev <= 1'h1;
            @(posedge clk);
            ev <= 1'h0;
            repeat (3) @(posedge clk);
            rd(REG_STATUS, {23'h0, i[0], 8'h1});
        end
        rd(REG_FIFO, 32'h9e);
        stop_test;
    end
endmodule
`default_nettype wire
